// file: verilog/cap_sense_control.sv
// Control and status register for the capacitive-sense converter
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Enable bit clear keeps converter in low power; set makes it ready.
// - Pin-monitor retry event while enabled sets a sticky flag until firmware clears it.
// - Each finished conversion sets the done flag.
// - Hardware never clears the done flag; only firmware writes do.
// - Busy reads one during a conversion, zero otherwise.
// - Writing busy one starts conversion only in modes 000b, 110b, 111b.
// - Comparator enable compares accumulated result to the two-byte threshold.
// - Result above threshold sets a sticky comparator flag until cleared.
// - Bits 2:1 read zero and ignore writes.
module cap_sense_control
  import cap_sense_pkg::*;
(
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          rst_n,
  // Register access
  input  wire cap_sense_pkg::sfr_req_type    sfr_req,
  output logic [7:0]                         sfr_rdata,
  // Converter side
  input  wire cap_sense_pkg::conv_event_type conv_evt,
  input  wire logic [2:0]                    start_mode_field,
  input  wire logic [7:0]                    threshold_high_byte,
  input  wire logic [7:0]                    threshold_low_byte,
  output logic                               converter_enable,
  output logic                               conv_start,
  output logic                               conv_busy_out
);
  import cap_sense_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic           enable_q;
  logic           pme_q;
  logic           done_q;
  logic           cmpen_q;
  logic           cmpf_q;
  logic           start_q;
  logic [7:0]     rdata_q;
  conv_state_type state_q;
  conv_state_type state_d;

  // ****************************************
  // Decode
  // ****************************************
  wire logic       hit      = sfr_req.addr == CTRL_ADDR;
  wire logic       wr_hit   = sfr_req.wr && hit;
  wire logic       rd_hit   = sfr_req.rd && hit;
  wire logic [7:0] wd       = sfr_req.wdata;
  wire logic       sw_mode  = (start_mode_field == MODE_SW_A) ||
                              (start_mode_field == MODE_SW_B) ||
                              (start_mode_field == MODE_SW_C);
  // Start ignored while idle-disabled or already running
  wire logic       sw_start = wr_hit && wd[BUSY_BIT] && sw_mode && enable_q &&
                              (state_q == CONV_IDLE);
  wire logic       running  = state_q == CONV_RUN;
  wire logic       finish   = running && conv_evt.done;
  wire logic [15:0] thresh  = {threshold_high_byte, threshold_low_byte};
  wire logic       over     = finish && cmpen_q && (conv_evt.result > thresh);
  wire logic       retry    = enable_q && conv_evt.retry;
  // Bits 2:1 forced to zero by the read mask
  wire logic [7:0] status   = {enable_q, pme_q, done_q, running, cmpen_q,
                               2'b00, cmpf_q} & CTRL_READ_MASK;

  // ****************************************
  // Conversion sequencer
  // ****************************************
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CONV_IDLE: if (sw_start) state_d = CONV_RUN;
      CONV_RUN:  if (finish || !enable_q) state_d = CONV_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= CONV_IDLE;
      start_q <= 1'b0;
    end else begin
      state_q <= state_d;
      start_q <= sw_start;
    end
  end

  // ****************************************
  // Control bits and sticky flags
  // ****************************************
  // Hardware set wins over a firmware clear in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= CTRL_RESET[ENABLE_BIT];
      pme_q    <= CTRL_RESET[PME_BIT];
      done_q   <= CTRL_RESET[DONE_BIT];
      cmpen_q  <= CTRL_RESET[CMPEN_BIT];
      cmpf_q   <= CTRL_RESET[CMPF_BIT];
    end else begin
      if (wr_hit) begin
        enable_q <= wd[ENABLE_BIT];
        cmpen_q  <= wd[CMPEN_BIT];
      end
      pme_q  <= retry  || (wr_hit ? wd[PME_BIT]  : pme_q);
      done_q <= finish || (wr_hit ? wd[DONE_BIT] : done_q);
      cmpf_q <= over   || (wr_hit ? wd[CMPF_BIT] : cmpf_q);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= CTRL_RESET;
    end else if (rd_hit) begin
      rdata_q <= status;
    end
  end

  assign sfr_rdata        = rdata_q;
  assign converter_enable = enable_q;
  assign conv_start       = start_q;
  assign conv_busy_out    = running;

  // ****************************************
  // Checks
  // ****************************************
  AST_DONE_SETS: assert property (@(posedge core_clk) disable iff (!rst_n)
    finish |=> done_q)
    else $error("done flag not set after conversion end");
  AST_BUSY_DROPS: assert property (@(posedge core_clk) disable iff (!rst_n)
    finish |=> (!conv_busy_out && done_q))
    else $error("busy not dropped with done flag");
  AST_DONE_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (done_q && !(wr_hit && !wd[DONE_BIT])) |=> done_q)
    else $error("done flag cleared without firmware");
  AST_PME_SETS: assert property (@(posedge core_clk) disable iff (!rst_n)
    retry |=> pme_q)
    else $error("pin monitor flag not set");
  AST_START_MODE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_hit && wd[BUSY_BIT] && enable_q && !running && sw_mode) |=> conv_busy_out)
    else $error("allowed start did not begin conversion");
  AST_NO_BAD_START: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!running && !sw_mode) |=> !conv_busy_out)
    else $error("conversion started in hardware mode");
  AST_CMP_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
    (finish && cmpen_q && conv_evt.result > thresh) |=> cmpf_q)
    else $error("comparator flag missed");
  AST_CMP_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!cmpen_q && !cmpf_q && !(wr_hit && wd[CMPF_BIT])) |=> !cmpf_q)
    else $error("comparator flag set while disabled");
  AST_UNUSED_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rd_hit) |=> (sfr_rdata[2:1] == 2'b00))
    else $error("unused bits read nonzero");
  AST_DISABLED_IDLE: assert property (@(posedge core_clk) disable iff (!rst_n)
    !enable_q |=> !conv_busy_out)
    else $error("converter busy while disabled");

  // ****************************************
  // Checks on the start strobe and busy
  // ****************************************
  AST_START_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
    sw_start |=> conv_start)
    else $error("start strobe missing");
  AST_START_ONE: assert property (@(posedge core_clk) disable iff (!rst_n)
    conv_start |=> !conv_start)
    else $error("start strobe longer than one cycle");
  AST_START_DISABLED: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_hit && wd[BUSY_BIT] && !enable_q) |=> !conv_start)
    else $error("start accepted while disabled");
  AST_BUSY_ZERO_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!running && !(wr_hit && wd[BUSY_BIT])) |=> !conv_busy_out)
    else $error("busy set without a start write");
  AST_BUSY_STAYS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && !finish && enable_q) |=> conv_busy_out)
    else $error("busy dropped before conversion end");
  AST_ABORT: assert property (@(posedge core_clk) disable iff (!rst_n)
    (running && !enable_q) |=> !conv_busy_out)
    else $error("conversion not stopped on disable");
  AST_READ_BUSY: assert property (@(posedge core_clk) disable iff (!rst_n)
    (rd_hit && running) |=> sfr_rdata[BUSY_BIT])
    else $error("busy bit reads zero during conversion");

  // ****************************************
  // Checks on the sticky flags
  // ****************************************
  AST_PME_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (pme_q && !(wr_hit && !wd[PME_BIT])) |=> pme_q)
    else $error("pin monitor flag lost");
  AST_PME_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_hit && !wd[PME_BIT] && !retry) |=> !pme_q)
    else $error("pin monitor flag not cleared");
  AST_DONE_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_hit && !wd[DONE_BIT] && !finish) |=> !done_q)
    else $error("done flag not cleared");
  AST_DONE_QUIET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!finish && !done_q && !(wr_hit && wd[DONE_BIT])) |=> !done_q)
    else $error("done flag set without a conversion");
  AST_IDLE_DONE_IGNORED: assert property (@(posedge core_clk) disable iff (!rst_n)
    (!running && conv_evt.done && !done_q && !(wr_hit && wd[DONE_BIT])) |=> !done_q)
    else $error("stray done accepted while idle");
  AST_CMPF_HOLDS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (cmpf_q && !(wr_hit && !wd[CMPF_BIT])) |=> cmpf_q)
    else $error("comparator flag lost");
  AST_CMP_NOT_OVER: assert property (@(posedge core_clk) disable iff (!rst_n)
    (finish && conv_evt.result <= thresh && !cmpf_q && !(wr_hit && wd[CMPF_BIT])) |=> !cmpf_q)
    else $error("comparator flag set without exceeding threshold");

  // ****************************************
  // Checks on the control bits
  // ****************************************
  AST_ENABLE_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_hit && wd[ENABLE_BIT]) |=> converter_enable)
    else $error("enable not set by write");
  AST_ENABLE_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_hit && !wd[ENABLE_BIT]) |=> !converter_enable)
    else $error("enable not cleared by write");
  AST_CMPEN_FOLLOWS: assert property (@(posedge core_clk) disable iff (!rst_n)
    (wr_hit && wd[CMPEN_BIT]) |=> cmpen_q)
    else $error("comparator enable not set by write");

endmodule
`default_nettype wire

// file: shared/cap_sense_pkg.sv
// Package for the capacitive-sense control and status logic
package cap_sense_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] CTRL_ADDR      = 8'h9a;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [7:0] CTRL_READ_MASK = 8'hf9;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int ENABLE_BIT  = 7;
  localparam int PME_BIT     = 6;
  localparam int DONE_BIT    = 5;
  localparam int BUSY_BIT    = 4;
  localparam int CMPEN_BIT   = 3;
  localparam int CMPF_BIT    = 0;

  // ****************************************
  // Start modes that allow a software start
  // ****************************************
  localparam logic [2:0] MODE_SW_A = 3'h0;
  localparam logic [2:0] MODE_SW_B = 3'h6;
  localparam logic [2:0] MODE_SW_C = 3'h7;

  localparam int RESULT_WIDTH = 16;

  typedef enum logic [0:0] {
    CONV_IDLE,
    CONV_RUN
  } conv_state_type;

  // Special function register access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  // Events from the analog converter
  typedef struct packed {
    logic                    done;
    logic                    retry;
    logic [RESULT_WIDTH-1:0] result;
  } conv_event_type;

endpackage

// file: testbench/cap_sense_converter_model.sv
// Behavioural converter and electrode model facing the control block
`timescale 1ns/10ps
`default_nettype none
module cap_sense_converter_model
  import cap_sense_pkg::*;
#(
  parameter int          LAT = 12,
  parameter logic [15:0] RES = 16'h1234
)(
  // Clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  // Control and events
  input  wire logic                     conv_start,
  input  wire logic                     retry_cmd,
  output var cap_sense_pkg::conv_event_type conv_evt
);
  int   cnt;
  logic done_w;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n)
      cnt <= 0;
    else if (conv_start)
      cnt <= LAT;
    else if (cnt > 0)
      cnt <= cnt - 1;
  end
  // Done fires even after an abort, so the block must ignore it
  assign done_w = (cnt == 1);
  // Inverse result outside the pulse catches early sampling
  assign conv_evt = '{done: done_w, retry: retry_cmd,
                      result: (done_w ? RES : ~RES)};
endmodule
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the capacitive-sense control register
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cap_sense_pkg::*;
  typedef struct packed {logic [2:0] m; logic [15:0] t; logic [7:0] e;} row_type;
  logic           core_clk = 1'b0;
  logic           rst_n = 1'b0;
  logic           retry_cmd = 1'b0;
  logic           en, cs, busy;
  logic [2:0]     mode = 3'h0;
  logic [15:0]    th = 16'h0000;
  logic [7:0]     rdata;
  sfr_req_type    sfr_req = '0;
  conv_event_type conv_evt;
  int             n_errors = 0;
  int             samples_checked = 0;
  // Strict compare: equal threshold must not flag
  row_type rows [8] = '{'{3'h0, 16'h1233, 8'ha9}, '{3'h1, 16'h0000, 8'h88},
    '{3'h2, 16'h0000, 8'h88}, '{3'h3, 16'h0000, 8'h88}, '{3'h4, 16'h0000, 8'h88},
    '{3'h5, 16'h0000, 8'h88}, '{3'h6, 16'h1234, 8'ha8}, '{3'h7, 16'h0000, 8'ha9}};
  cap_sense_control DUT (.core_clk(core_clk), .rst_n(rst_n), .sfr_req(sfr_req),
    .sfr_rdata(rdata), .conv_evt(conv_evt), .start_mode_field(mode),
    .threshold_high_byte(th[15:8]), .threshold_low_byte(th[7:0]),
    .converter_enable(en), .conv_start(cs), .conv_busy_out(busy));
  cap_sense_converter_model model (.core_clk(core_clk), .rst_n(rst_n),
    .conv_start(cs), .retry_cmd(retry_cmd), .conv_evt(conv_evt));
  // ********
  // Tasks
  // ********
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge core_clk);
    sfr_req.wr <= 1'b1;
    sfr_req.addr <= a;
    sfr_req.wdata <= d;
    @(posedge core_clk);
    sfr_req.wr <= 1'b0;
  endtask
  // Checks on the falling edge, away from the edge that launches read data
  task automatic rd(string name, logic [7:0] e);
    @(posedge core_clk);
    sfr_req.rd <= 1'b1;
    sfr_req.addr <= CTRL_ADDR;
    @(posedge core_clk);
    sfr_req.rd <= 1'b0;
    @(negedge core_clk);
    chk(name, rdata, e);
    $display("test %s done", name);
    @(posedge core_clk);
  endtask
  // Two edges first: busy only shows after the start write has landed
  task automatic wait_idle();
    repeat (2) @(posedge core_clk);
    for (int i = 0; i < 40 && busy !== 1'b0; i++)
      @(posedge core_clk);
    repeat (4) @(posedge core_clk);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial forever #2 core_clk = ~core_clk;
  initial begin
    #20000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd("reset value", CTRL_RESET);
    wr(CTRL_ADDR, 8'h90);
    @(negedge core_clk);
    chk("enable", {7'h00, en}, 8'h01);
    rd("start with enable ignored", 8'h80);
    foreach (rows[i]) begin
      mode <= rows[i].m;
      th <= rows[i].t;
      wr(CTRL_ADDR, 8'h98);
      wait_idle();
      rd("mode row", rows[i].e);
    end
    mode <= 3'h0;
    th <= 16'h0000;
    wr(CTRL_ADDR, 8'h90);
    wait_idle();
    rd("comparator off", 8'ha0);
    wr(CTRL_ADDR, 8'he7);
    rd("flags set unused zero", 8'he1);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd("second reset", CTRL_RESET);
    wr(CTRL_ADDR, 8'h80);
    wr(8'h9b, 8'hff);
    rd("other address", 8'h80);
    retry_cmd <= 1'b1;
    @(posedge core_clk);
    retry_cmd <= 1'b0;
    rd("retry flag", 8'hc0);
    wr(CTRL_ADDR, 8'h90);
    @(negedge core_clk);
    chk("start pulse", {7'h00, cs}, 8'h01);
    @(negedge core_clk);
    chk("start pulse width", {7'h00, cs}, 8'h00);
    chk("busy pin", {7'h00, busy}, 8'h01);
    rd("busy while running", 8'h90);
    wr(CTRL_ADDR, 8'h00);
    wait_idle();
    // Stray done from the aborted run lands in this gap
    repeat (8) @(posedge core_clk);
    rd("abort", 8'h00);
    report_and_stop();
  end
endmodule
`default_nettype wire
